// ---- inc/regulator_control_pkg.sv ----
// Constants for the regulator control register bank
package regulator_control_pkg;
   // Functional-page addresses
   localparam logic [7:0] ADDR_REF_OUT_CTL   = 8'h6A;
   localparam logic [7:0] ADDR_BACKUP_CTL    = 8'h6B;
   localparam logic [7:0] ADDR_REG_A_CTL     = 8'h6C;
   localparam logic [7:0] ADDR_REG_B_CTL     = 8'h6D;
   // Field positions
   localparam int         REF_ON_BIT         = 0;
   localparam int         OFF_MODE_BIT       = 7;
   localparam int         LOW_POWER_BIT      = 6;
   localparam int         STANDBY_OFF_BIT    = 5;
   localparam int         ON_BIT             = 4;
   localparam int         VCODE_MSB          = 3;
   localparam int         BACKUP_CODE_MSB    = 2;
   // Writable masks
   localparam logic [7:0] REF_OUT_MASK       = 8'h01;
   localparam logic [7:0] BACKUP_MASK        = 8'h07;
   localparam logic [7:0] LINEAR_MASK        = 8'hFF;
   // Reset values of fixed fields and the OTP field mask
   localparam logic [7:0] REF_OUT_RESET      = 8'h00;
   localparam logic [7:0] LINEAR_FIXED_RESET = 8'h00;
   localparam logic [7:0] OTP_FIELD_MASK     = 8'h1F;
   // Only legal backup voltage code (3.0 V)
   localparam logic [2:0] BACKUP_CODE_VALID  = 3'h6;
   // Regulator operating modes
   typedef enum logic [3:0] {
      MODE_OFF   = 4'h1,
      MODE_ON    = 4'h2,
      MODE_LOWP  = 4'h4,
      MODE_SLEEP = 4'h8
   } reg_mode_t;
endpackage

// ---- hw/linear_reg_mode.sv ----
// Mode selector for one linear regulator
`timescale 1ns/1ns
module linear_reg_mode
   import regulator_control_pkg::*;
(
   // Control register
   input  wire logic [7:0] ctl_i,
   // System state
   input  wire logic       standby_i,
   input  wire logic       low_power_cond_i,
   input  wire logic       turn_off_i,
   // Resulting mode
   output reg_mode_t       mode_o
);
   always_comb begin
      if (turn_off_i) begin
         mode_o = ctl_i[OFF_MODE_BIT] ? MODE_SLEEP : MODE_OFF; // [R6] [R12]
      end else if (!ctl_i[ON_BIT]) begin
         mode_o = MODE_OFF; // [R9] [R15]
      end else if (standby_i && ctl_i[STANDBY_OFF_BIT]) begin
         mode_o = MODE_OFF; // [R8] [R16]
      end else if (low_power_cond_i && ctl_i[LOW_POWER_BIT]) begin
         mode_o = MODE_LOWP; // [R7] [R17]
      end else begin
         mode_o = MODE_ON;
      end
   end
endmodule // linear_reg_mode

// ---- hw/regulator_control_registers.sv ----
// Control registers for reference, backup and two linear regulators
//
// Summary of operation
// [R1] Bit 0 of reference control turns the DDR reference output on.
// [R2] Reference control at 0x6A, resets to zero, only bit 0 exists.
// [R3] Backup voltage code sits in bits 2:0; bits 7:3 read zero.
// [R4] Only code 110 is valid and default; host must not write others.
// [R5] Backup control at 0x6B; code resets from OTP configuration.
// [R6] On enable-pin turn-off, regulator A goes off (bit7=0) or sleep (bit7=1).
// [R7] Regulator A may enter low power only while bit 6 is set.
// [R8] In standby, regulator A is off when bit 5 is set.
// [R9] Bit 4 enables regulator A.
// [R10] Regulator A voltage code comes from bits 3:0.
// [R11] Regulator A control at 0x6C; bits 7:5 zero, 4:0 from OTP.
// [R12] On turn-off, regulator B goes off (bit7=0) or sleep (bit7=1).
// [R13] Regulator B control at 0x6D with same field layout, 7:5 reset zero.
// [R14] All registers readable and writable at any time, no locking; writes are dropped in the OTP load cycle after reset.
// [R15] Bit 4 enables regulator B.
// [R16] In standby, regulator B is off when bit 5 is set.
// [R17] Regulator B may enter low power only while bit 6 is set.
// [R18] Unimplemented bits read zero; writes to them are ignored.
`timescale 1ns/1ns
module regulator_control_registers
   import regulator_control_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   // Register port from serial control logic
   input  wire logic [7:0] addr_i,
   input  wire logic       wr_en_i,
   input  wire logic [7:0] wr_data_i,
   input  wire logic       rd_en_i,
   output logic      [7:0] rd_data_o,
   // OTP defaults, sampled after reset release
   input  wire logic [2:0] otp_backup_code_i,
   input  wire logic [4:0] otp_reg_a_i,
   input  wire logic [4:0] otp_reg_b_i,
   // System state
   input  wire logic       standby_i,
   input  wire logic       low_power_cond_i,
   input  wire logic       turn_off_i,
   // Analog controls
   output logic            reference_output_on_o,
   output logic      [2:0] backup_voltage_code_o,
   output logic            reg_a_on_o,
   output logic            reg_a_sleep_o,
   output logic            reg_a_low_power_o,
   output logic      [3:0] reg_a_voltage_code_o,
   output logic            reg_b_on_o,
   output logic            reg_b_sleep_o,
   output logic            reg_b_low_power_o,
   output logic      [3:0] reg_b_voltage_code_o
);

   logic      [7:0] ref_ctl_reg,    ref_ctl_next;
   logic      [7:0] backup_ctl_reg, backup_ctl_next;
   logic      [7:0] reg_a_ctl_reg,  reg_a_ctl_next;
   logic      [7:0] reg_b_ctl_reg,  reg_b_ctl_next;
   logic            otp_load_reg,   otp_load_next;
   logic      [7:0] rd_data_reg,    rd_data_next;
   reg_mode_t       mode_a;
   reg_mode_t       mode_b;

   // Masked write of a register
   function automatic logic [7:0] masked_write(input logic [7:0] mask,
                                               input logic [7:0] data);
      masked_write = data & mask; // [R18]
   endfunction

   // Write strobe aimed at one register address
   function automatic logic write_hit(input logic       en,
                                      input logic [7:0] addr,
                                      input logic [7:0] target);
      write_hit = en && (addr == target);
   endfunction

   // Host writes, held off while the OTP load runs
   logic            wr_ok;
   assign wr_ok = wr_en_i && !otp_load_reg; // [R14]

   // One-shot OTP load on the first edge after reset
   always_comb begin
      otp_load_next = 1'b0;
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         otp_load_reg <= 1'b1;
      end else begin
         otp_load_reg <= otp_load_next;
      end
   end

   // Reference output control register
   always_comb begin
      ref_ctl_next = ref_ctl_reg;
      if (write_hit(wr_ok, addr_i, ADDR_REF_OUT_CTL)) begin
         ref_ctl_next = masked_write(REF_OUT_MASK, wr_data_i); // [R2]
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ref_ctl_reg <= REF_OUT_RESET; // [R2]
      end else begin
         ref_ctl_reg <= ref_ctl_next;
      end
   end

   // Backup supply control register
   always_comb begin
      backup_ctl_next = backup_ctl_reg;
      if (otp_load_reg) begin
         backup_ctl_next = {5'h00, otp_backup_code_i}; // [R5]
      end else if (write_hit(wr_ok, addr_i, ADDR_BACKUP_CTL)) begin
         backup_ctl_next = masked_write(BACKUP_MASK, wr_data_i); // [R3]
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         backup_ctl_reg <= {5'h00, BACKUP_CODE_VALID}; // [R4]
      end else begin
         backup_ctl_reg <= backup_ctl_next;
      end
   end

   // Regulator A control register
   always_comb begin
      reg_a_ctl_next = reg_a_ctl_reg;
      if (otp_load_reg) begin
         reg_a_ctl_next = LINEAR_FIXED_RESET | ({3'h0, otp_reg_a_i} & OTP_FIELD_MASK); // [R11]
      end else if (write_hit(wr_ok, addr_i, ADDR_REG_A_CTL)) begin
         reg_a_ctl_next = masked_write(LINEAR_MASK, wr_data_i); // [R11]
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         reg_a_ctl_reg <= LINEAR_FIXED_RESET;
      end else begin
         reg_a_ctl_reg <= reg_a_ctl_next;
      end
   end

   // Regulator B control register
   always_comb begin
      reg_b_ctl_next = reg_b_ctl_reg;
      if (otp_load_reg) begin
         reg_b_ctl_next = LINEAR_FIXED_RESET | ({3'h0, otp_reg_b_i} & OTP_FIELD_MASK); // [R13]
      end else if (write_hit(wr_ok, addr_i, ADDR_REG_B_CTL)) begin
         reg_b_ctl_next = masked_write(LINEAR_MASK, wr_data_i); // [R13]
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         reg_b_ctl_reg <= LINEAR_FIXED_RESET;
      end else begin
         reg_b_ctl_reg <= reg_b_ctl_next;
      end
   end

   // Read data
   always_comb begin
      rd_data_next = rd_data_reg;
      if (rd_en_i) begin
         // [R14]
         unique case (addr_i)
            ADDR_REF_OUT_CTL: rd_data_next = ref_ctl_reg & REF_OUT_MASK; // [R18]
            ADDR_BACKUP_CTL:  rd_data_next = backup_ctl_reg & BACKUP_MASK; // [R18]
            ADDR_REG_A_CTL:   rd_data_next = reg_a_ctl_reg;
            ADDR_REG_B_CTL:   rd_data_next = reg_b_ctl_reg;
            default:          rd_data_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rd_data_reg <= 8'h00;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end

   // Mode decoding shared by both regulators
   function automatic logic mode_running(input reg_mode_t mode);
      mode_running = (mode == MODE_ON) || (mode == MODE_LOWP); // [R9] [R15]
   endfunction

   function automatic logic mode_sleeping(input reg_mode_t mode);
      mode_sleeping = (mode == MODE_SLEEP); // [R6] [R12]
   endfunction

   function automatic logic mode_low_power(input reg_mode_t mode);
      mode_low_power = (mode == MODE_LOWP); // [R7] [R17]
   endfunction

   function automatic logic [3:0] vcode_field(input logic [7:0] ctl);
      vcode_field = ctl[VCODE_MSB:0]; // [R10] [R13]
   endfunction

   // Regulator mode selection
   linear_reg_mode u_mode_a (
      .ctl_i            (reg_a_ctl_reg),
      .standby_i        (standby_i),
      .low_power_cond_i (low_power_cond_i),
      .turn_off_i       (turn_off_i),
      .mode_o           (mode_a)
   ); // [R6] [R7] [R8] [R9]

   linear_reg_mode u_mode_b (
      .ctl_i            (reg_b_ctl_reg),
      .standby_i        (standby_i),
      .low_power_cond_i (low_power_cond_i),
      .turn_off_i       (turn_off_i),
      .mode_o           (mode_b)
   ); // [R12] [R15] [R16] [R17]

   // Reference output enable
   logic            ref_on_reg,      ref_on_next;

   always_comb begin
      ref_on_next = ref_ctl_reg[REF_ON_BIT]; // [R1]
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ref_on_reg <= 1'b0;
      end else begin
         ref_on_reg <= ref_on_next;
      end
   end

   // Backup supply voltage code
   logic      [2:0] backup_code_reg, backup_code_next;

   always_comb begin
      backup_code_next = backup_ctl_reg[BACKUP_CODE_MSB:0]; // [R3]
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         backup_code_reg <= BACKUP_CODE_VALID; // [R4]
      end else begin
         backup_code_reg <= backup_code_next;
      end
   end

   // Regulator A controls
   logic            a_on_reg,        a_on_next;
   logic            a_sleep_reg,     a_sleep_next;
   logic            a_lowp_reg,      a_lowp_next;
   logic      [3:0] a_code_reg,      a_code_next;

   always_comb begin
      a_on_next    = mode_running(mode_a); // [R9]
      a_sleep_next = mode_sleeping(mode_a); // [R6]
      a_lowp_next  = mode_low_power(mode_a); // [R7]
      a_code_next  = vcode_field(reg_a_ctl_reg); // [R10]
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         a_on_reg    <= 1'b0;
         a_sleep_reg <= 1'b0;
         a_lowp_reg  <= 1'b0;
         a_code_reg  <= 4'h0;
      end else begin
         a_on_reg    <= a_on_next;
         a_sleep_reg <= a_sleep_next;
         a_lowp_reg  <= a_lowp_next;
         a_code_reg  <= a_code_next;
      end
   end

   // Regulator B controls
   logic            b_on_reg,        b_on_next;
   logic            b_sleep_reg,     b_sleep_next;
   logic            b_lowp_reg,      b_lowp_next;
   logic      [3:0] b_code_reg,      b_code_next;

   always_comb begin
      b_on_next    = mode_running(mode_b); // [R15]
      b_sleep_next = mode_sleeping(mode_b); // [R12]
      b_lowp_next  = mode_low_power(mode_b); // [R17]
      b_code_next  = vcode_field(reg_b_ctl_reg); // [R13]
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         b_on_reg    <= 1'b0;
         b_sleep_reg <= 1'b0;
         b_lowp_reg  <= 1'b0;
         b_code_reg  <= 4'h0;
      end else begin
         b_on_reg    <= b_on_next;
         b_sleep_reg <= b_sleep_next;
         b_lowp_reg  <= b_lowp_next;
         b_code_reg  <= b_code_next;
      end
   end

   assign rd_data_o             = rd_data_reg;
   assign reference_output_on_o = ref_on_reg;
   assign backup_voltage_code_o = backup_code_reg;
   assign reg_a_on_o            = a_on_reg;
   assign reg_a_sleep_o         = a_sleep_reg;
   assign reg_a_low_power_o     = a_lowp_reg;
   assign reg_a_voltage_code_o  = a_code_reg;
   assign reg_b_on_o            = b_on_reg;
   assign reg_b_sleep_o         = b_sleep_reg;
   assign reg_b_low_power_o     = b_lowp_reg;
   assign reg_b_voltage_code_o  = b_code_reg;

endmodule // regulator_control_registers

// ---- verif/regulator_control_assertions.sv ----
// Checker for the regulator control register bank
`timescale 1ns/1ns
module regulator_control_assertions (
   // Watched ports
   input wire logic       ref_clk_i,
   input wire logic       rst_i,
   input wire logic [7:0] addr_i,
   input wire logic       wr_en_i,
   input wire logic [7:0] wr_data_i,
   input wire logic       rd_en_i,
   input wire logic [7:0] rd_data_o,
   input wire logic       standby_i,
   input wire logic       turn_off_i,
   input wire logic       reference_output_on_o,
   input wire logic       reg_a_on_o,
   input wire logic       reg_a_low_power_o,
   input wire logic       reg_b_on_o,
   input wire logic       reg_b_sleep_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   sequence wr_at(logic [7:0] a); wr_en_i && !$past(rst_i) && addr_i == a; endsequence
   AST_REF_ON: assert property (wr_at(8'h6A) |-> ##2
      reference_output_on_o == $past(wr_data_i[0], 2)) else $error("ref on");
   AST_BK_RD: assert property (rd_en_i && addr_i == 8'h6B |=> rd_data_o[7:3] == 5'h00)
      else $error("backup read");
   AST_A_OFF: assert property (wr_at(8'h6C) ##0 !(wr_data_i[7] || wr_data_i[4])
      |-> ##2 !reg_a_on_o) else $error("a on");
   AST_A_NO_LOWP: assert property (wr_at(8'h6C) ##0 !wr_data_i[6] |-> ##2
      !reg_a_low_power_o) else $error("a low power");
   AST_B_STBY: assert property (wr_at(8'h6D) ##0 wr_data_i[5:4] == 2'h3 ##1 standby_i
      |=> !reg_b_on_o) else $error("b standby");
   AST_B_SLEEP: assert property (wr_at(8'h6D) ##0 wr_data_i[7] ##1 turn_off_i
      |=> reg_b_sleep_o && !reg_b_on_o) else $error("b sleep");
   AST_REF_RD: assert property (rd_en_i && addr_i == 8'h6A |=> rd_data_o[7:1] == 7'h00)
      else $error("ref read");
   AST_UNMAPPED: assert property (rd_en_i && (addr_i < 8'h6A || addr_i > 8'h6D) |=>
      rd_data_o == 8'h00) else $error("unmapped read");
   cover property (wr_at(8'h6C));
   cover property (turn_off_i && reg_b_sleep_o);
   cover property (rd_en_i && addr_i == 8'h6E);
endmodule // regulator_control_assertions
bind regulator_control_registers regulator_control_assertions chk (.*);

// ---- verif/regulator_host.sv ----
// Host model on the register port
`timescale 1ns/1ns
module regulator_host (
   // Clock and register port
   input  wire logic       ref_clk_i,
   output logic      [7:0] addr_o,
   output logic            wr_en_o,
   output logic      [7:0] wr_data_o,
   output logic            rd_en_o,
   input  wire logic [7:0] rd_data_i
);
   initial {addr_o, wr_en_o, wr_data_o, rd_en_o} = 18'h0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      {addr_o, wr_data_o, wr_en_o, rd_en_o} = {a, d, 2'h2};
      @(negedge ref_clk_i);
      wr_en_o = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk_i);
      {addr_o, wr_data_o, wr_en_o, rd_en_o} = {a, ~wr_data_o, 2'h1};
      @(negedge ref_clk_i);
      d = rd_data_i;
      {addr_o, rd_en_o} = {~a, 1'b0};
   endtask
endmodule // regulator_host

// ---- verif/regulator_control_registers_test.sv ----
// Bench for the regulator control register bank
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
   $display("Error %0t got %h exp %h", $time, g, e); end end
module regulator_control_registers_test;
   logic       ref_clk_i = 1'b0;
   logic       rst_i, standby_i, low_power_cond_i, turn_off_i, wr_en_i, rd_en_i;
   logic [7:0] addr_i, wr_data_i, rd_data_o, d;
   logic [3:0] reg_a_voltage_code_o, reg_b_voltage_code_o;
   logic [2:0] backup_voltage_code_o;
   logic       reference_output_on_o, reg_a_on_o, reg_a_sleep_o, reg_a_low_power_o;
   logic       reg_b_on_o, reg_b_sleep_o, reg_b_low_power_o;
   int         miscompares = 0, n_compared = 0;
   regulator_host host (.ref_clk_i, .addr_o(addr_i), .wr_en_o(wr_en_i),
      .wr_data_o(wr_data_i), .rd_en_o(rd_en_i), .rd_data_i(rd_data_o));
   regulator_control_registers uut (.*, .otp_backup_code_i(3'h6), .otp_reg_a_i(5'h15),
      .otp_reg_b_i(5'h0A));
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, d);
      `CHK(d, e)
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial forever #20 ref_clk_i = ~ref_clk_i;
   initial begin
      #100000;
      miscompares++;
      tally_and_finish();
   end
   initial begin
      {rst_i, standby_i, low_power_cond_i, turn_off_i} = 4'h8;
      repeat (6) @(negedge ref_clk_i);
      rst_i = 1'b0;
      rchk(8'h6A, 8'h00);
      `CHK({reg_a_on_o, reg_a_voltage_code_o, reg_b_on_o, reg_b_voltage_code_o}, 10'h2AA)
      rchk(8'h6C, 8'h15);
      rchk(8'h6D, 8'h0A);
      host.wr(8'h6A, 8'hFF);
      host.wr(8'h6B, 8'hFE);
      host.wr(8'h6E, 8'h00);
      rchk(8'h6A, 8'h01);
      rchk(8'h6B, 8'h06);
      rchk(8'h6E, 8'h00);
      `CHK({reference_output_on_o, backup_voltage_code_o}, 4'hE)
      {standby_i, low_power_cond_i} = 2'h3;
      host.wr(8'h6C, 8'h5A);
      host.wr(8'h6D, 8'hB3);
      rchk(8'h6C, 8'h5A);
      `CHK({reg_a_on_o, reg_a_low_power_o, reg_a_voltage_code_o, reg_b_on_o}, 7'h74)
      turn_off_i = 1'b1;
      host.wr(8'h6D, 8'hB3);
      rchk(8'h6D, 8'hB3);
      `CHK({reg_a_on_o, reg_a_sleep_o, reg_b_on_o, reg_b_sleep_o}, 4'h1)
      {standby_i, turn_off_i} = 2'h0;
      host.wr(8'h6C, 8'h0F);
      rchk(8'h6C, 8'h0F);
      `CHK({reg_a_on_o, reg_b_on_o, reg_b_low_power_o, reg_b_voltage_code_o}, 7'h23)
      standby_i = 1'b1;
      host.wr(8'h6D, 8'h5C);
      host.wr(8'h6C, 8'hB7);
      rchk(8'h6D, 8'h5C);
      `CHK({reg_b_on_o, reg_b_low_power_o, reg_b_voltage_code_o, reg_a_on_o}, 7'h78)
      turn_off_i = 1'b1;
      rchk(8'h6C, 8'hB7);
      `CHK({reg_a_sleep_o, reg_a_on_o, reg_b_sleep_o, reg_b_on_o}, 4'h8)
      tally_and_finish();
   end
endmodule // regulator_control_registers_test
